// [srt_pkg.sv]
// constants, types and helpers for the split and reload timers
// Operation
// - first timer split mode runs low and high bytes as two 8-bit counters
// - split low byte uses first timer run, select, gate, flag; clock or pin
// - split high byte is a timer only, on system or prescaled clock
// - split high byte gated by second run bit, sets second overflow flag
// - during split the second timer runs modes 0-2, no pin, no flag
// - during split the second timer overflow still feeds baud and ADC tick
// - during split the second timer runs in modes 0-2, stops in mode 3
// - third timer is 16 bits made of low and high byte registers
// - third timer control bit 3 picks 16-bit or split 8-bit reload
// - third timer clock: system, /12, slow oscillator /8, comparator
// - 16-bit wrap loads reload value and sets high overflow flag bit 7
// - every 16-bit overflow interrupts when enable bit 5 is set
// - low byte wrap also interrupts when control bit 5 and enable set
// - capture mode measures slow oscillator or comparator period
package srt_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_TCTL = 8'h00;
    localparam logic [7:0] OFS_TIMER_MODE_REG = 8'h04;
    localparam logic [7:0] OFS_TL0 = 8'h08;
    localparam logic [7:0] OFS_TH0 = 8'h0C;
    localparam logic [7:0] OFS_TL1 = 8'h10;
    localparam logic [7:0] OFS_TH1 = 8'h14;
    localparam logic [7:0] OFS_T2CTL = 8'h18;
    localparam logic [7:0] OFS_RLL = 8'h1C;
    localparam logic [7:0] OFS_RLH = 8'h20;
    localparam logic [7:0] OFS_T2L = 8'h24;
    localparam logic [7:0] OFS_T2H = 8'h28;
    localparam logic [7:0] OFS_IE = 8'h2C;
    localparam logic [7:0] OFS_IST = 8'h30;
    localparam logic [7:0] OFS_ICLR = 8'h34;

    // timer_control_reg fields
    localparam int TC_T0_SYS = 0;
    localparam int TC_T1_SYS = 1;
    localparam int TC_TR0 = 4;
    localparam int TC_TF0 = 5;
    localparam int TC_TR1 = 6;
    localparam int TC_TF1 = 7;
    localparam logic [7:0] TC_WMASK = 8'h53;

    // timer_mode_reg fields
    localparam int TM_M0_LSB = 0;
    localparam int TM_CT0 = 2;
    localparam int TM_FIRST_TIMER_GATE = 3;
    localparam int TM_M1_LSB = 4;
    localparam int TM_CT1 = 6;
    localparam int TM_GATE1 = 7;
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // third_timer_control_reg fields
    localparam int T2_TFH = 7;
    localparam int T2_TFL = 6;
    localparam int T2_LIE = 5;
    localparam int T2_CAP = 4;
    localparam int T2_SPLIT = 3;
    localparam int T2_RUN = 2;
    localparam logic [7:0] T2_WMASK = 8'h3F;
    localparam logic [1:0] CS_SYS = 2'h0;
    localparam logic [1:0] CS_DIV12 = 2'h1;
    localparam logic [1:0] CS_SLOW8 = 2'h2;
    localparam logic [1:0] CS_CMP = 2'h3;

    // interrupt status / enable / clear layout
    localparam int IR_T0 = 1;
    localparam int IR_T1 = 3;
    localparam int IR_T2H = 5;
    localparam int IR_T2L = 6;
    localparam logic [7:0] IR_MASK = 8'h6A;

    // reset value and divider counts
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [3:0] PRESCALE_LAST = 4'(12 - 1);
    localparam logic [2:0] SLOW_LAST = 3'(8 - 1);

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } srt_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } srt_apb_rsp_t;

    typedef struct packed {
        logic comp_in;
        logic slow_osc_in;
        logic gate1_in;
        logic first_timer_gate_in;
        logic t1_in;
        logic t0_in;
    } srt_pins_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic ovh;
        logic ovl;
    } srt_t2_state_t;

    typedef struct packed {
        logic [7:0] tctl;
        logic [7:0] timer_mode_reg;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [7:0] t2ctl;
        logic [7:0] rll;
        logic [7:0] rlh;
        logic [7:0] ie;
        logic [7:0] st;
        logic [3:0] p12;
        logic [2:0] s8;
        logic [3:0] prev;
        srt_apb_rsp_t rsp;
        logic irq;
        logic baud;
    } srt_state_t;

    // one count step of a mode 0/1/2 timer: {overflow, high, low}
    function automatic logic [16:0] srt_step(input logic [1:0] m,
                                             input logic [7:0] h,
                                             input logic [7:0] l);
        logic [16:0] r;
        logic [13:0] c;
        c = {1'b0, h, l[4:0]} + 14'h0001;
        case (m)
            MODE_13BIT: r = {c[13], c[12:5], l[7:5], c[4:0]};
            MODE_16BIT: r = {1'b0, h, l} + 17'h00001;
            MODE_RELOAD8: begin
                if (l == 8'hFF) r = {1'b1, h, h};
                else r = {1'b0, h, l + 8'h01};
            end
            default: r = {1'b0, h, l};
        endcase
        return r;
    endfunction

endpackage

// [srt_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module srt_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [1:0][W-1:0] s_reg;
    logic [1:0][W-1:0] s_next;

    always_comb begin
        s_next = {s_reg[0], din};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign dout = s_reg[1];
endmodule

// [srt_timers.sv]
// first, second and third timers with APB registers and interrupt
`timescale 1ns/10ps
module srt_timers (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire srt_pkg::srt_apb_req_t apb_req,
    output srt_pkg::srt_apb_rsp_t apb_rsp,
    // pins
    input wire srt_pkg::srt_pins_t pins,
    // events
    output logic irq,
    output logic second_timer_ovf_tick
);
    import srt_pkg::*;

    srt_state_t s_reg;
    srt_state_t s_next;
    srt_pins_t ps;
    logic [15:0] t2_cnt;
    logic t2_ovh;
    logic t2_ovl;
    logic tick2;
    logic wr_t2l;
    logic wr_t2h;
    logic tick12, e_t0, e_t1, e_slow, e_cmp, tick_s8;
    logic split0, pre0, pre1, tk0, tk1, run0, run1, ov1, cap_evt;
    logic acc, wr, hit;
    logic [1:0] m1;
    logic [16:0] r;
    logic [7:0] rd, clr, set;

    srt_sync #(.W(6)) srt_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .din(pins),
        .dout(ps)
    );

    srt_tmr2 srt_tmr2_inst (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick2),
        .run(s_reg.t2ctl[T2_RUN]),
        .split(s_reg.t2ctl[T2_SPLIT]),
        .reload({s_reg.rlh, s_reg.rll}),
        .wr_low(wr_t2l),
        .wr_high(wr_t2h),
        .wdata(apb_req.pwdata[7:0]),
        .count(t2_cnt),
        .ovf_high(t2_ovh),
        .ovf_low(t2_ovl)
    );

    always_comb begin
        s_next = s_reg;
        set = 8'h00;
        clr = 8'h00;
        rd = 8'h00;
        hit = 1'b1;
        r = 17'h00000;
        ov1 = 1'b0;
        s_next.baud = 1'b0;

        // shared clock enables
        tick12 = (s_reg.p12 == PRESCALE_LAST);
        s_next.p12 = tick12 ? 4'h0 : s_reg.p12 + 4'h1;
        e_t0 = s_reg.prev[0] & ~ps.t0_in;
        e_t1 = s_reg.prev[1] & ~ps.t1_in;
        e_slow = ~s_reg.prev[2] & ps.slow_osc_in;
        e_cmp = ~s_reg.prev[3] & ps.comp_in;
        s_next.prev = {ps.comp_in, ps.slow_osc_in, ps.t1_in, ps.t0_in};
        tick_s8 = e_slow && (s_reg.s8 == SLOW_LAST);
        if (e_slow) s_next.s8 = s_reg.s8 + 3'h1;

        // first timer
        split0 = (s_reg.timer_mode_reg[TM_M0_LSB +: 2] == MODE_SPLIT);
        pre0 = s_reg.tctl[TC_T0_SYS] | tick12;
        pre1 = s_reg.tctl[TC_T1_SYS] | tick12;
        tk0 = s_reg.timer_mode_reg[TM_CT0] ? e_t0 : pre0;
        run0 = s_reg.tctl[TC_TR0]
            & (~s_reg.timer_mode_reg[TM_FIRST_TIMER_GATE] | ps.first_timer_gate_in);
        if (split0) begin
            if (run0 && tk0) begin
                s_next.tl0 = s_reg.tl0 + 8'h01;
                set[IR_T0] = (s_reg.tl0 == 8'hFF);
            end
            if (s_reg.tctl[TC_TR1] && pre0) begin
                s_next.th0 = s_reg.th0 + 8'h01;
                set[IR_T1] = (s_reg.th0 == 8'hFF);
            end
        end else if (run0 && tk0) begin
            r = srt_step(s_reg.timer_mode_reg[TM_M0_LSB +: 2], s_reg.th0, s_reg.tl0);
            set[IR_T0] = r[16];
            s_next.th0 = r[15:8];
            s_next.tl0 = r[7:0];
        end

        // second timer
        m1 = s_reg.timer_mode_reg[TM_M1_LSB +: 2];
        if (split0) begin
            tk1 = pre1;
            run1 = (m1 != MODE_SPLIT);
        end else begin
            tk1 = s_reg.timer_mode_reg[TM_CT1] ? e_t1 : pre1;
            run1 = s_reg.tctl[TC_TR1] & (m1 != MODE_SPLIT)
                & (~s_reg.timer_mode_reg[TM_GATE1] | ps.gate1_in);
        end
        if (run1 && tk1) begin
            r = srt_step(m1, s_reg.th1, s_reg.tl1);
            ov1 = r[16];
            s_next.th1 = r[15:8];
            s_next.tl1 = r[7:0];
            s_next.baud = ov1;
            if (!split0) set[IR_T1] = ov1;
        end

        // third timer clock and capture
        case (s_reg.t2ctl[1:0])
            CS_SYS: tick2 = 1'b1;
            CS_DIV12: tick2 = tick12;
            CS_SLOW8: tick2 = tick_s8;
            CS_CMP: tick2 = e_cmp;
            default: tick2 = 1'b0;
        endcase
        cap_evt = s_reg.t2ctl[T2_CAP]
            & ((s_reg.t2ctl[1:0] == CS_CMP) ? tick_s8 : e_cmp);
        if (cap_evt) begin
            s_next.rll = t2_cnt[7:0];
            s_next.rlh = t2_cnt[15:8];
        end
        set[IR_T2H] = t2_ovh | cap_evt;
        set[IR_T2L] = t2_ovl;

        // bus access: answer one cycle into the access phase
        acc = apb_req.psel & apb_req.penable;
        case (apb_req.paddr)
            OFS_TCTL: begin
                rd = s_reg.tctl;
                rd[TC_TF0] = s_reg.st[IR_T0];
                rd[TC_TF1] = s_reg.st[IR_T1];
            end
            OFS_TIMER_MODE_REG: rd = s_reg.timer_mode_reg;
            OFS_TL0: rd = s_reg.tl0;
            OFS_TH0: rd = s_reg.th0;
            OFS_TL1: rd = s_reg.tl1;
            OFS_TH1: rd = s_reg.th1;
            OFS_T2CTL: begin
                rd = s_reg.t2ctl;
                rd[T2_TFH] = s_reg.st[IR_T2H];
                rd[T2_TFL] = s_reg.st[IR_T2L];
            end
            OFS_RLL: rd = s_reg.rll;
            OFS_RLH: rd = s_reg.rlh;
            OFS_T2L: rd = t2_cnt[7:0];
            OFS_T2H: rd = t2_cnt[15:8];
            OFS_IE: rd = s_reg.ie;
            OFS_IST: rd = s_reg.st;
            OFS_ICLR: rd = 8'h00;
            default: hit = 1'b0;
        endcase
        s_next.rsp.pready = acc & ~s_reg.rsp.pready;
        s_next.rsp.pslverr = 1'b0;
        if (acc && !s_reg.rsp.pready) begin
            s_next.rsp.prdata = {24'h000000, rd};
            s_next.rsp.pslverr = ~hit;
        end
        wr = acc & s_reg.rsp.pready & apb_req.pwrite & hit;
        wr_t2l = wr && (apb_req.paddr == OFS_T2L);
        wr_t2h = wr && (apb_req.paddr == OFS_T2H);
        if (wr) begin
            case (apb_req.paddr)
                OFS_TCTL: s_next.tctl = apb_req.pwdata[7:0] & TC_WMASK;
                OFS_TIMER_MODE_REG: s_next.timer_mode_reg = apb_req.pwdata[7:0];
                OFS_TL0: s_next.tl0 = apb_req.pwdata[7:0];
                OFS_TH0: s_next.th0 = apb_req.pwdata[7:0];
                OFS_TL1: s_next.tl1 = apb_req.pwdata[7:0];
                OFS_TH1: s_next.th1 = apb_req.pwdata[7:0];
                OFS_T2CTL: s_next.t2ctl = apb_req.pwdata[7:0] & T2_WMASK;
                OFS_RLL: s_next.rll = apb_req.pwdata[7:0];
                OFS_RLH: s_next.rlh = apb_req.pwdata[7:0];
                OFS_IE: s_next.ie = apb_req.pwdata[7:0] & IR_MASK;
                OFS_ICLR: clr = apb_req.pwdata[7:0] & IR_MASK;
                default: clr = 8'h00;
            endcase
        end

        // sticky flags: a set in the clearing cycle wins
        s_next.st = (s_reg.st & ~clr) | set;
        s_next.irq = (s_reg.st[IR_T0] & s_reg.ie[IR_T0])
            | (s_reg.st[IR_T1] & s_reg.ie[IR_T1])
            | (s_reg.st[IR_T2H] & s_reg.ie[IR_T2H])
            | (s_reg.st[IR_T2L] & s_reg.ie[IR_T2H]
               & s_reg.t2ctl[T2_LIE]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign apb_rsp = s_reg.rsp;
    assign irq = s_reg.irq;
    assign second_timer_ovf_tick = s_reg.baud;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    split_low_a: assert property (
        split0 && run0 && tk0 && s_reg.tl0 == 8'hFF
        |=> s_reg.st[IR_T0] && s_reg.tl0 == 8'h00 || wr)
        else $error("split low byte wrap lost its flag");
    split_high_a: assert property (
        split0 && s_reg.tctl[TC_TR1] && pre0 && s_reg.th0 == 8'hFF
        |=> s_reg.st[IR_T1])
        else $error("split high byte wrap lost its flag");
    high_gate_a: assert property (
        split0 && !s_reg.tctl[TC_TR1] && !wr
        |=> $stable(s_reg.th0))
        else $error("split high byte ran without run bit");
    second_noflag_a: assert property (
        split0 && !s_reg.tctl[TC_TR1] |=> !$rose(s_reg.st[IR_T1]))
        else $error("second timer set its flag during split");
    second_tick_a: assert property (
        split0 && run1 && tk1 && ov1 |=> second_timer_ovf_tick)
        else $error("second timer overflow tick missing");
    second_stop_a: assert property (
        split0 && m1 == MODE_SPLIT && !wr
        |=> $stable({s_reg.th1, s_reg.tl1}))
        else $error("second timer ran in mode 3");
    second_run_a: assert property (
        split0 && m1 != MODE_SPLIT && pre1 && !wr
        && !(m1 == MODE_RELOAD8 && s_reg.tl1 == 8'hFF)
        |=> !$stable({s_reg.th1, s_reg.tl1}))
        else $error("second timer stopped in modes 0-2");
    t2_flag_a: assert property (
        t2_ovh |=> s_reg.st[IR_T2H])
        else $error("third timer overflow flag not set");
    wide_irq_a: assert property (
        s_reg.st[IR_T2H] && s_reg.ie[IR_T2H] |=> irq)
        else $error("third timer interrupt missing");
    low_irq_a: assert property (
        s_reg.st[IR_T2L] && !s_reg.t2ctl[T2_LIE] && s_reg.st[IR_T2H] == 0
        && (s_reg.st & s_reg.ie & 8'h0A) == 8'h00 |=> !irq)
        else $error("low byte interrupt without its option");
    bus_answer_a: assert property (
        acc && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("bus access not answered");

    split_wrap_c: cover property (split0 && set[IR_T1]);
    capture_c: cover property (cap_evt);
    low_irq_c: cover property (t2_ovl && s_reg.t2ctl[T2_LIE]);
endmodule

// [srt_tmr2.sv]
// third timer counter: 16-bit or split 8-bit auto-reload
`timescale 1ns/10ps
module srt_tmr2 (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic tick,
    input wire logic run,
    input wire logic split,
    input wire logic [15:0] reload,
    // software writes
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    // state
    output logic [15:0] count,
    output logic ovf_high,
    output logic ovf_low
);
    import srt_pkg::*;

    srt_t2_state_t s_reg;
    srt_t2_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.ovh = 1'b0;
        s_next.ovl = 1'b0;
        if (run && tick) begin
            if (split) begin
                if (s_reg.cnt[7:0] == 8'hFF) begin
                    s_next.cnt[7:0] = reload[7:0];
                    s_next.ovl = 1'b1;
                end else begin
                    s_next.cnt[7:0] = s_reg.cnt[7:0] + 8'h01;
                end
                if (s_reg.cnt[15:8] == 8'hFF) begin
                    s_next.cnt[15:8] = reload[15:8];
                    s_next.ovh = 1'b1;
                end else begin
                    s_next.cnt[15:8] = s_reg.cnt[15:8] + 8'h01;
                end
            end else if (s_reg.cnt == 16'hFFFF) begin
                s_next.cnt = reload;
                s_next.ovh = 1'b1;
                s_next.ovl = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 16'h0001;
                s_next.ovl = (s_reg.cnt[7:0] == 8'hFF);
            end
        end
        if (wr_low) s_next.cnt[7:0] = wdata;
        if (wr_high) s_next.cnt[15:8] = wdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign count = s_reg.cnt;
    assign ovf_high = s_reg.ovh;
    assign ovf_low = s_reg.ovl;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    wide_reload_a: assert property (
        run && tick && !split && count == 16'hFFFF && !wr_low && !wr_high
        |=> count == $past(reload) && ovf_high)
        else $error("16-bit wrap did not reload");
    split_reload_a: assert property (
        run && tick && split && count[15:8] == 8'hFF && !wr_high
        |=> count[15:8] == $past(reload[15:8]) && ovf_high)
        else $error("split high byte did not reload");
endmodule

// [tb_srt_timers.sv]
// self-checking testbench for the split and reload timers
`timescale 1ns/10ps
module tb_srt_timers;
    import srt_pkg::*;
    logic pclk;
    logic presetn;
    srt_apb_req_t apb_req;
    srt_apb_rsp_t apb_rsp;
    srt_pins_t pins;
    logic irq;
    logic second_timer_ovf_tick;
    int mismatches;
    int samples_checked;
    int ticks;
    int phase;
    int t0;

    srt_timers srt_timers_inst (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .pins(pins),
        .irq(irq),
        .second_timer_ovf_tick(second_timer_ovf_tick)
    );

    always #50 pclk = ~pclk;

    // slow oscillator rises every 4 cycles, comparator every 6
    always @(posedge pclk) begin
        phase <= phase + 1;
        pins.slow_osc_in <= (phase % 4) >= 2;
        pins.comp_in <= (phase % 6) >= 3;
    end

    always @(posedge pclk) begin
        if (second_timer_ovf_tick === 1'b1) ticks <= ticks + 1;
    end

    task automatic finish_test();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input logic [15:0] lo,
                           input logic [15:0] hi, input logic [15:0] g);
        samples_checked++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            mismatches++;
            $display("Error %s expected %h..%h seen %h", nm, lo, hi, g);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= {24'h000000, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 16'h0001, 16'h0000);
        q = apb_rsp.prdata[7:0];
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic e;
        apb(1'b0, a, 8'h00, q, e);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            pins.t0_in <= 1'b1;
            repeat (3) @(posedge pclk);
            pins.t0_in <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask

    task automatic test_reset();
        logic [7:0] q;
        logic e;
        rdc("timer control", OFS_TCTL, 8'h00);
        rdc("timer mode", OFS_TIMER_MODE_REG, 8'h00);
        rdc("third control", OFS_T2CTL, 8'h00);
        rdc("status", OFS_IST, 8'h00);
        apb(1'b0, 8'h3C, 8'h00, q, e);
        chk("unmapped error", 16'h0001, {15'h0000, e});
        chk("unmapped data", 16'h0000, {8'h00, q});
    endtask

    task automatic test_rates();
        logic [15:0] lo[4] = '{16'h017E, 16'h001F, 16'h000A, 16'h003E};
        logic [15:0] hi[4] = '{16'h018A, 16'h0022, 16'h000E, 16'h0043};
        logic [7:0] l8;
        logic [7:0] h8;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_T2CTL, 8'h00);
            wr(OFS_T2L, 8'h00);
            wr(OFS_T2H, 8'h00);
            wr(OFS_T2CTL, 8'h04 | 8'(i));
            repeat (384) @(posedge pclk);
            wr(OFS_T2CTL, 8'(i));
            rd(OFS_T2L, l8);
            rd(OFS_T2H, h8);
            chk_rng("third count", lo[i], hi[i], {h8, l8});
        end
    endtask

    task automatic test_reload16();
        wr(OFS_RLL, 8'h34);
        wr(OFS_RLH, 8'h12);
        wr(OFS_T2L, 8'hF0);
        wr(OFS_T2H, 8'hFF);
        wr(OFS_ICLR, 8'hFF);
        wr(OFS_IE, 8'h20);
        wr(OFS_T2CTL, 8'h04);
        repeat (30) @(posedge pclk);
        rdc("third high", OFS_T2H, 8'h12);
        rdc("status", OFS_IST, 8'h60);
        rdc("third control", OFS_T2CTL, 8'hC4);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(OFS_IE, 8'h00);
        repeat (2) @(posedge pclk);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(OFS_IE, 8'h20);
        repeat (2) @(posedge pclk);
        chk("irq unmasked", 16'h0001, {15'h0000, irq});
        wr(OFS_T2CTL, 8'h00);
        wr(OFS_ICLR, 8'h60);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        rdc("status cleared", OFS_IST, 8'h00);
        rdc("clear reg", OFS_ICLR, 8'h00);
    endtask

    task automatic test_split8();
        logic [7:0] q;
        wr(OFS_RLL, 8'h80);
        wr(OFS_RLH, 8'h40);
        wr(OFS_T2L, 8'hF8);
        wr(OFS_T2H, 8'h00);
        wr(OFS_T2CTL, 8'h2C);
        repeat (20) @(posedge pclk);
        wr(OFS_T2CTL, 8'h28);
        rd(OFS_T2L, q);
        chk_rng("split low", 16'h008C, 16'h0094, {8'h00, q});
        rd(OFS_T2H, q);
        chk_rng("split high", 16'h0015, 16'h001B, {8'h00, q});
        rdc("status", OFS_IST, 8'h40);
        chk("low irq", 16'h0001, {15'h0000, irq});
        wr(OFS_ICLR, 8'hFF);
    endtask

    task automatic test_capture();
        wr(OFS_T2CTL, 8'h00);
        wr(OFS_T2L, 8'h00);
        wr(OFS_T2H, 8'h00);
        wr(OFS_T2CTL, 8'h14);
        repeat (20) @(posedge pclk);
        wr(OFS_T2CTL, 8'h00);
        rdc("capture status", OFS_IST, 8'h20);
        rdc("captured high", OFS_RLH, 8'h00);
        wr(OFS_ICLR, 8'hFF);
    endtask

    task automatic test_split_first();
        logic [7:0] q;
        wr(OFS_IE, 8'h0A);
        wr(OFS_TIMER_MODE_REG, 8'h13);
        wr(OFS_TL1, 8'hF0);
        wr(OFS_TH1, 8'hFF);
        wr(OFS_TL0, 8'hF0);
        wr(OFS_TH0, 8'hF0);
        t0 = ticks;
        wr(OFS_TCTL, 8'h13);
        repeat (40) @(posedge pclk);
        rdc("status", OFS_IST, 8'h02);
        rdc("first high", OFS_TH0, 8'hF0);
        chk("ovf ticks", 16'h0001, 16'(ticks - t0));
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(OFS_TCTL, 8'h53);
        repeat (20) @(posedge pclk);
        rdc("status", OFS_IST, 8'h0A);
        wr(OFS_TCTL, 8'h13);
        wr(OFS_ICLR, 8'hFF);
        wr(OFS_TIMER_MODE_REG, 8'h33);
        wr(OFS_TL1, 8'hF0);
        wr(OFS_TH1, 8'hFF);
        t0 = ticks;
        repeat (40) @(posedge pclk);
        chk("stopped ticks", 16'h0000, 16'(ticks - t0));
        wr(OFS_TIMER_MODE_REG, 8'h13);
        repeat (40) @(posedge pclk);
        chk("ovf ticks", 16'h0001, 16'(ticks - t0));
        rd(OFS_IST, q);
        chk("second flag", 16'h0000, {15'h0000, q[3]});
    endtask

    task automatic test_external();
        wr(OFS_TCTL, 8'h00);
        wr(OFS_ICLR, 8'hFF);
        wr(OFS_TIMER_MODE_REG, 8'h0F);
        wr(OFS_TL0, 8'h00);
        wr(OFS_TCTL, 8'h10);
        pins.first_timer_gate_in <= 1'b1;
        pulse(5);
        repeat (6) @(posedge pclk);
        pins.first_timer_gate_in <= 1'b0;
        pulse(3);
        repeat (8) @(posedge pclk);
        rdc("first low", OFS_TL0, 8'h05);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        finish_test();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        pins = '0;
        mismatches = 0;
        samples_checked = 0;
        ticks = 0;
        phase = 0;
        t0 = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_rates();
        test_reload16();
        test_split8();
        test_capture();
        test_split_first();
        test_external();
        finish_test();
    end
endmodule
